// ===== core/rita_pkg.sv
/*
 * package for the register init and test access block: mode codes, widths,
 * power-up clear timing and the apb register map.
 * assumes a single 50 MHz clock and a 32-bit apb master.
 */
package rita_pkg;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int POWER_UP_CLEAR_INTERVAL_NS = 10000;
   // longest time rounds down
   localparam int POWER_UP_CLEAR_CYCLES = POWER_UP_CLEAR_INTERVAL_NS / CLK_PERIOD_NS;
   localparam int CLEAR_CNT_W = 10;

   // ****************************************************************
   // test modes
   // ****************************************************************
   typedef enum logic [1:0] {
      RITA_NORMAL = 2'h0,
      RITA_PRELOAD = 2'h1,
      RITA_OBSERVE = 2'h2
   } rita_mode_t;

   // power-up sequencer, one-hot
   typedef enum logic [1:0] {
      RITA_CLEARING = 2'b01,
      RITA_RUNNING = 2'b10
   } rita_seq_t;

   // ****************************************************************
   // apb register map (byte addresses)
   // ****************************************************************
   localparam logic [11:0] OFS_MODE = 12'h000;
   localparam logic [11:0] OFS_POLARITY = 12'h004;
   localparam logic [11:0] OFS_COMBSEL = 12'h008;
   localparam logic [11:0] OFS_OE = 12'h00C;
   localparam logic [11:0] OFS_ASYNC = 12'h010;
   localparam logic [11:0] OFS_STATE = 12'h014;
   localparam logic [11:0] OFS_STATUS = 12'h018;
   localparam logic [11:0] OFS_PIN_OUT = 12'h01C;
   localparam int MODE_LSB = 0;
   localparam int STATUS_READY_BIT = 0;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam int ASYNC_RST_LSB = 0;
   localparam int ASYNC_SET_LSB = 16;
endpackage : rita_pkg

// ===== core/rita_apb_if.sv
/*
 * apb carrier between the top and its register slave.
 * assumes one clock shared by both ends.
 */
interface rita_apb_if;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic wrStb;
   logic rdStb;
   modport slave (input psel, penable, pwrite, paddr, pwdata, output pready, pslverr, wrStb, rdStb);
   modport core (input wrStb, rdStb, paddr, pwdata, output prdata);
endinterface : rita_apb_if

// ===== core/rita_apb_slave.sv
/*
 * apb slave handshake: zero wait states, one-cycle write and read strobes.
 * assumes the master holds the request until pready.
 */
module rita_apb_slave
   import rita_pkg::*;
(
   rita_apb_if.slave bus
);
   // ****************************************************************
   // handshake
   // ****************************************************************
   // always ready, writes act in the access phase
   assign bus.pready = 1'b1;
   assign bus.wrStb = bus.psel & bus.penable & bus.pwrite;
   // read strobe in setup so registered read data stands in the access phase
   assign bus.rdStb = bus.psel & ~bus.penable & ~bus.pwrite;
   // unmapped: any offset past the last word or not aligned
   assign bus.pslverr = bus.psel & bus.penable & ((bus.paddr > OFS_PIN_OUT) | (bus.paddr[1:0] != 2'h0));
endmodule : rita_apb_slave

// ===== core/rita_reg_array.sv
/*
 * register array with power-up clear, preload, observe, async reset and
 * preset terms and combinatorial/registered output cells.
 * assumes: pins are synchronous to ref_clk; the user logic next-state and
 * combinatorial product-sum values arrive on plain ports from the array logic.
 */
// The placing of the registers and register access over APB are this design's own decisions.
module rita_reg_array
   import rita_pkg::*;
#(
   parameter int N = 16
)(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N-1:0] pinIn,
   input wire logic [N-1:0] logicNext,
   input wire logic [N-1:0] productSum,
   output logic [N-1:0] pinOut,
   output logic [N-1:0] pinOeN,
   output logic clearDone
);
   rita_apb_if bus ();
   rita_seq_t seq_q;
   logic [CLEAR_CNT_W-1:0] clrCnt_q;
   rita_mode_t mode_q;
   logic [N-1:0] polarity_q, combSel_q, oe_q, ffs_q, rstTerm_q, setTerm_q;
   logic [N-1:0] ffs_d, rawOut, asyncRst, asyncSet;
   logic [31:0] prdata_q;
   logic testMode, running;

   assign bus.psel = psel;
   assign bus.penable = penable;
   assign bus.pwrite = pwrite;
   assign bus.paddr = paddr;
   assign bus.pwdata = pwdata;
   assign pready = bus.pready;
   assign pslverr = bus.pslverr;
   assign bus.prdata = prdata_q;
   assign prdata = bus.prdata;

   rita_apb_slave u_slave (
      .bus(bus)
   );

   function automatic logic [31:0] widen(input logic [N-1:0] v);
      widen = 32'(v);
   endfunction

   // ****************************************************************
   // power-up clear sequencer
   // ****************************************************************
   // clear count bounded
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         seq_q <= RITA_CLEARING;
         clrCnt_q <= '0;
      end else begin
         unique case (seq_q)
            RITA_CLEARING: begin
               clrCnt_q <= clrCnt_q + 1'b1;
               if (clrCnt_q == CLEAR_CNT_W'(POWER_UP_CLEAR_CYCLES - 1)) begin
                  seq_q <= RITA_RUNNING;
               end
            end
            RITA_RUNNING: begin
               clrCnt_q <= clrCnt_q;
            end
            default: begin
               seq_q <= RITA_CLEARING;
            end
         endcase
      end
   end
   assign running = (seq_q == RITA_RUNNING);
   assign clearDone = running;

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   // mode selection
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mode_q <= RITA_NORMAL;
         polarity_q <= '0;
         combSel_q <= '0;
         oe_q <= '0;
         rstTerm_q <= '0;
         setTerm_q <= '0;
      end else if (bus.wrStb && !bus.pslverr) begin
         unique case (paddr)
            OFS_MODE: begin
               if (pwdata[MODE_LSB +: 2] != 2'h3) begin
                  mode_q <= rita_mode_t'(pwdata[MODE_LSB +: 2]);
               end
            end
            OFS_POLARITY: polarity_q <= pwdata[N-1:0];
            OFS_COMBSEL: combSel_q <= pwdata[N-1:0];
            OFS_OE: oe_q <= pwdata[N-1:0];
            OFS_ASYNC: begin
               rstTerm_q <= pwdata[ASYNC_RST_LSB +: N];
               setTerm_q <= pwdata[ASYNC_SET_LSB +: N];
            end
            default: ;
         endcase
      end
   end
   assign testMode = (mode_q != RITA_NORMAL);

   // ****************************************************************
   // flip-flop array
   // ****************************************************************
   // async terms are driven by register contents
   assign asyncRst = {N{|(ffs_q & rstTerm_q)}};
   assign asyncSet = {N{|(ffs_q & setTerm_q)}} & ~asyncRst;

   // next value, async terms win over preload and logic
   always_comb begin
      ffs_d = ffs_q;
      if (!running) begin
         ffs_d = '0;
      end else begin
         unique case (mode_q)
            RITA_PRELOAD: ffs_d = pinIn;
            RITA_NORMAL: ffs_d = logicNext;
            default: ffs_d = ffs_q;
         endcase
         ffs_d = (ffs_d & ~(asyncRst & rstTerm_q)) | (asyncSet & setTerm_q);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ffs_q <= '0;
      end else begin
         ffs_q <= ffs_d;
      end
   end

   // ****************************************************************
   // output cells
   // ****************************************************************
   // combinatorial forced registered in test modes, productSum ignored
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (combSel_q[i] && !testMode) begin
            rawOut[i] = productSum[i];
         end else begin
            rawOut[i] = ffs_q[i];
         end
      end
   end

   // polarity applied; observe forces enables on
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pinOut <= '0;
         pinOeN <= '1;
      end else begin
         pinOut <= rawOut ^ polarity_q;
         if (mode_q == RITA_OBSERVE) begin
            pinOeN <= '0;
         end else if (mode_q == RITA_PRELOAD) begin
            pinOeN <= '1;
         end else begin
            pinOeN <= ~oe_q;
         end
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   // loads in the setup cycle, so the word is valid while pready is high
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         prdata_q <= RST_ZERO;
      end else if (bus.rdStb) begin
         unique case (paddr)
            OFS_MODE: prdata_q <= 32'(mode_q);
            OFS_POLARITY: prdata_q <= widen(polarity_q);
            OFS_COMBSEL: prdata_q <= widen(combSel_q);
            OFS_OE: prdata_q <= widen(oe_q);
            OFS_ASYNC: prdata_q <= widen(rstTerm_q) | (widen(setTerm_q) << ASYNC_SET_LSB);
            OFS_STATE: prdata_q <= widen(ffs_q);
            OFS_STATUS: prdata_q <= 32'(running);
            OFS_PIN_OUT: prdata_q <= widen(pinOut);
            default: prdata_q <= RST_ZERO;
         endcase
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   clear_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst) !running |=> (ffs_q == '0))
      else $error("flip-flops not cleared");
   clear_bound_a: assert property (@(posedge ref_clk) $fell(sys_rst) |-> ##[499:500] running)
      else $error("clear interval wrong");
   preload_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (running && mode_q == RITA_PRELOAD && !(|(ffs_q & (rstTerm_q | setTerm_q)))) |=> (ffs_q == $past(pinIn)))
      else $error("preload lost");
   observe_oe_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mode_q == RITA_OBSERVE |=> (pinOeN == '0))
      else $error("observe enable not forced");
   async_rst_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (running && |(ffs_q & rstTerm_q)) |=> ((ffs_q & $past(rstTerm_q)) == '0))
      else $error("async reset ignored");
   polarity_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!running ##1 !running) |=> (pinOut == $past(polarity_q)))
      else $error("polarity wrong after clear");
   test_reg_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      testMode |=> (pinOut == ($past(ffs_q) ^ $past(polarity_q))))
      else $error("comb output not registered");
   comb_restore_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!testMode && combSel_q[0]) |=> (pinOut[0] == ($past(productSum[0]) ^ $past(polarity_q[0]))))
      else $error("comb output not restored");
endmodule : rita_reg_array

// ===== sim/rita_pin_tester.sv
/*
 * tester model on the pin side of the register array.
 * assumes the bench changes drvEn and drvVal just after a rising edge.
 */
module rita_pin_tester #(
   parameter int N = 16
)(
   input wire logic ref_clk,
   input wire logic [N-1:0] pinOeN,
   input wire logic [N-1:0] pinOut,
   input wire logic drvEn,
   input wire logic [N-1:0] drvVal,
   output logic [N-1:0] pinLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [N-1:0] lastQ = '0;
   // tester drives pins
   // device wins where enabled, else tester, else a float that toggles
   assign pinLevel = (~pinOeN & pinOut) | (pinOeN & (drvEn ? drvVal : ~lastQ));
   // setup before edges
   // levels only move after an edge, so setup always holds
   always @(posedge ref_clk) begin
      lastQ <= pinLevel;
   end
endmodule // rita_pin_tester

// ===== sim/register_init_and_test_access_test.sv
/*
 * self-checking bench: apb master, pin tester model, queue-based checker.
 * assumes read data stands in the apb access phase and is taken at the pready edge.
 */
module register_init_and_test_access_test
   import rita_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic refClk = 1'b0, sysRst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, drvEn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, got;
   logic pready, pslverr, clearDone;
   logic [15:0] pinIn, pinOut, pinOeN, pol, v, ps, pv;
   logic [15:0] logicNext = 16'h0000, productSum = 16'h0000, drvVal = 16'h0000;
   logic [2:0] lookSel = 3'h0;
   logic [31:0] expQ[$];
   int n_fail = 0, checks = 0, cyc = 0;
   integer seed = 48383;

   rita_reg_array #(.N(16)) rita_reg_array_inst (.ref_clk(refClk), .sys_rst(sysRst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .logicNext(logicNext),
      .productSum(productSum), .pinOut(pinOut), .pinOeN(pinOeN), .clearDone(clearDone));
   rita_pin_tester #(.N(16)) rita_pin_tester_inst (.ref_clk(refClk), .pinOeN(pinOeN),
      .pinOut(pinOut), .drvEn(drvEn), .drvVal(drvVal), .pinLevel(pinIn));

   // 50 MHz clock
   initial begin
      forever #10 refClk = ~refClk;
   end

   // ****************************************************************
   // reporting
   // ****************************************************************
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // oldest note against the selected output
   always @(posedge refClk) begin
      // bus looks wait for the completing access edge, the rest look at once
      if ((lookSel == 3'h1 || lookSel == 3'h5) ? (psel && penable && pready === 1'b1) : (lookSel != 3'h0)) begin
         got = (lookSel == 3'h1) ? prdata : (lookSel == 3'h2) ? {16'h0000, pinOut} :
            (lookSel == 3'h3) ? {31'h0000_0000, clearDone} :
            (lookSel == 3'h5) ? {31'h0000_0000, pslverr} : {16'h0000, pinOeN};
         checks++;
         if (got !== expQ[0]) begin
            n_fail++;
            $display("BAD %0t: output %0d is %h, expected %h", $time, lookSel, got, expQ[0]);
         end
         void'(expQ.pop_front());
      end
   end

   // cut a hang short
   always @(posedge refClk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         give_verdict();
      end
   end

   // ****************************************************************
   // bus and note tasks
   // ****************************************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge refClk);
      penable <= 1'b1;
      do @(posedge refClk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic note(input logic [2:0] s, input logic [31:0] e);
      expQ.push_back(e);
      lookSel <= s;
      @(posedge refClk);
      lookSel <= 3'h0;
      @(posedge refClk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      @(posedge refClk);
   endtask

   // read whose answer is taken at the edge that samples pready high
   task automatic look_bus(input logic [2:0] s, input logic [11:0] a, input logic [31:0] e);
      expQ.push_back(e);
      lookSel <= s;
      apb(1'b0, a, 32'h0000_0000);
      lookSel <= 3'h0;
      @(posedge refClk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      look_bus(3'h1, a, e);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      repeat (10) @(posedge refClk);
      sysRst <= 1'b0;
      logicNext <= 16'($random(seed));
      @(posedge refClk);
      rd(OFS_STATE, RST_ZERO);
      note(3'h3, RST_ZERO);
      repeat (POWER_UP_CLEAR_CYCLES - 6) @(posedge refClk);
      note(3'h3, 32'h0000_0001);
      $display("power-up clear test done");
      pol = 16'($random(seed));
      logicNext <= 16'h0000;
      wr(OFS_POLARITY, {16'h0000, pol});
      wr(OFS_OE, 32'h0000_FFFF);
      note(3'h2, {16'h0000, pol});
      wr(OFS_MODE, 32'h0000_0003);
      rd(OFS_MODE, RST_ZERO);
      rd(OFS_POLARITY, {16'h0000, pol});
      rd(12'h020, RST_ZERO);
      look_bus(3'h5, 12'h020, 32'h0000_0001);
      v = 16'($random(seed));
      logicNext <= v;
      repeat (3) @(posedge refClk);
      rd(OFS_STATE, {16'h0000, v});
      ps = 16'($random(seed));
      productSum <= ps;
      wr(OFS_COMBSEL, 32'h0000_00FF);
      note(3'h2, {16'h0000, ((ps & 16'h00FF) | (v & 16'hFF00)) ^ pol});
      $display("normal mode test done");
      pv = 16'($random(seed)) | 16'h0001;
      drvVal <= pv;
      drvEn <= 1'b1;
      wr(OFS_MODE, 32'h0000_0001);
      repeat (3) @(posedge refClk);
      rd(OFS_STATE, {16'h0000, pv});
      note(3'h4, 32'h0000_FFFF);
      drvVal <= 16'h0001;
      wr(OFS_ASYNC, 32'h0003_0000);
      repeat (3) @(posedge refClk);
      rd(OFS_STATE, 32'h0000_0003);
      wr(OFS_ASYNC, RST_ZERO);
      logicNext <= pv;
      drvVal <= pv;
      wr(OFS_OE, RST_ZERO);
      repeat (3) @(posedge refClk);
      $display("preload test done");
      wr(OFS_MODE, 32'h0000_0002);
      drvEn <= 1'b0;
      repeat (3) @(posedge refClk);
      note(3'h4, RST_ZERO);
      note(3'h2, {16'h0000, pv ^ pol});
      wr(OFS_ASYNC, 32'h0000_00FF);
      repeat (3) @(posedge refClk);
      rd(OFS_STATE, {16'h0000, pv & 16'hFF00});
      wr(OFS_ASYNC, RST_ZERO);
      wr(OFS_MODE, RST_ZERO);
      ps = 16'($random(seed));
      productSum <= ps;
      repeat (3) @(posedge refClk);
      note(3'h2, {16'h0000, ((ps & 16'h00FF) | (pv & 16'hFF00)) ^ pol});
      $display("observe test done");
      give_verdict();
   end
endmodule // register_init_and_test_access_test
